// ==== pkg/acr_cfg.svh ====
/*
 configuration constants for the converter setup and result registers.
 assumes inclusion by bare name from the device, host, checker and bench modules.
*/
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
`define ACR_SETUP_RESET 8'hF0
`define ACR_EN_LSB 4
`define ACR_EN_MSB 7
`define ACR_REFSEL_BIT 3
`define ACR_BUS_GLITCH_FILTER_BYPASS_BIT 2
`define ACR_BTD_BIT 1
`define ACR_SMD_BIT 0
`define ACR_TAG_MSB 13
`define ACR_TAG_LSB 12
`define ACR_DATA_MSB 11
`define ACR_RES_BITS 12
`define ACR_CONV_CYCLES 6'h32
`define ACR_QUIET_CYCLES 4'h4
`define ACR_REG_CTRL 32'h00000000
`define ACR_REG_SETUP 32'h00000004
`define ACR_REG_STATUS 32'h00000008
`define ACR_REG_RESULT 32'h0000000C
`endif

// ==== pkg/acr_pkg.sv ====
/*
 types shared by both ends of the setup/result link.
 assumes acr_cfg.svh for all numeric constants.
*/
package acr_pkg;
    typedef enum logic [1:0] {ACR_CH0, ACR_CH1, ACR_CH2, ACR_CH3} acr_chan_t;
    typedef enum {ACR_IDLE, ACR_QUIET, ACR_CONV} acr_dev_state_t;
    typedef enum {ACR_H_IDLE, ACR_H_WR, ACR_H_RDHI, ACR_H_RDLO} acr_host_state_t;
endpackage : acr_pkg

// ==== pkg/acr_if.sv ====
/*
 link between controller (host) and converter control (device).
 assumes one clock shared by both ends; byte stream replaces the serial bus.
*/
`timescale 1ns/100ps
interface acr_if;
    logic wr_stb;
    logic [7:0] wr_byte;
    logic rd_req;
    logic rd_stb;
    logic [7:0] rd_byte;
    logic rd_byte_hi;
    logic bus_busy;
    modport dev (input wr_stb, wr_byte, rd_req, bus_busy,
        output rd_stb, rd_byte, rd_byte_hi);
    modport host (output wr_stb, wr_byte, rd_req, bus_busy,
        input rd_stb, rd_byte, rd_byte_hi);
endinterface : acr_if

// ==== src/acr_device.sv ====
/*
 converter control: setup register, channel sequencer, result register.
// Operation
// R1: upper setup bits enable inputs 0..3
// R2: enabled inputs converted in ascending turn
// R3: host clears enables of unused inputs
// R4: host enables channels before triggering conversion
// R5: reference bit 0: supply reference, four inputs
// R6: reference bit 1: fourth input is reference
// R7: bit D2 bypasses bus glitch filter
// R8: both delay bits 0: wait quiet bus
// R9: both delay bits 1: ignore bus activity
// R10: delay bits reset to zero
// R11: host keeps bus idle during conversion
// R12: 16-bit read-only unsigned result register
// R13: result read high byte then low
// R14: two zeros, channel tag, left-aligned result
// R15: 10-bit variant zeroes two low bits
// R16: 8-bit variant zeroes four low bits
// R17: first written byte loads setup register
// R18: all four enables set at reset
// R19: channel tag is binary input number
// R20: mixed delay bits keep delay protection
 assumes rd_req pulses once per two-byte read; sample_i is analog code.
*/
`timescale 1ns/100ps
`include "acr_cfg.svh"
module acr_device
    import acr_pkg::*;
#(
    parameter int RES_BITS = `ACR_RES_BITS
)(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // link
    acr_if.dev lnk,
    // analog side
    input wire logic [11:0] sample_i,
    output logic [1:0] mux_sel_o,
    output logic ext_ref_o,
    output logic filter_bypass_o,
    output logic [7:0] setup_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] setup_reg;
    logic [15:0] result_reg;
    logic [1:0] chan_reg;
    logic [5:0] cnt_reg;
    logic hi_pend_reg;
    acr_dev_state_t st_reg;
    logic [3:0] en;
    logic delay_on;
    logic [1:0] next_ch;
    logic [11:0] masked;

    // lowest enabled input above a given one, wrapping
    function automatic logic [1:0] pick_next(input logic [3:0] e,
        input logic [1:0] cur);
        logic [1:0] c;
        logic [1:0] r;
        logic hit;
        r = cur;
        hit = 1'b0;
        for (int k = 1; k <= 4; k++)
        begin
            // scan cur+1 .. cur+4: current input is tried last
            c = cur + 2'(k);
            if (!hit && e[c])
            begin
                r = c;
                hit = 1'b1;
            end
        end
        return r;
    endfunction : pick_next

    // ref select removes input 3 from the sequence
    assign en = setup_reg[`ACR_EN_MSB:`ACR_EN_LSB] &
        {~setup_reg[`ACR_REFSEL_BIT], 3'h7}; // [R1] [R5] [R6]
    // delay off only when both bits set
    assign delay_on = ~(setup_reg[`ACR_BTD_BIT] &
        setup_reg[`ACR_SMD_BIT]); // [R8] [R9] [R20]
    // next input of the sequence, wrapping past input 3
    assign next_ch = pick_next(en, chan_reg); // [R2]

    always_comb
    begin
        masked = sample_i;
        if (RES_BITS == 10)
            masked[1:0] = 2'h0; // [R15]
        else if (RES_BITS == 8)
            masked[3:0] = 4'h0; // [R16]
    end

    ////////////////////////////////////////////////////////////////////////
    // setup register
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            setup_reg <= `ACR_SETUP_RESET; // [R10] [R18]
        else if (lnk.wr_stb)
            setup_reg <= lnk.wr_byte; // [R17]
    end

    // conversion sequencer
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_reg <= ACR_IDLE;
            cnt_reg <= 6'h00;
            chan_reg <= 2'h3;
            result_reg <= 16'h0000;
        end
        else
        begin
            unique case (st_reg)
                ACR_IDLE:
                    // a new setup restarts at the lowest enabled input
                    if (lnk.wr_stb)
                        chan_reg <= 2'h3; // [R2]
                    else if (lnk.rd_req && en != 4'h0)
                    begin
                        chan_reg <= next_ch; // [R2]
                        st_reg <= ACR_QUIET;
                        cnt_reg <= 6'h00;
                    end
                ACR_QUIET:
                    if (!delay_on || !lnk.bus_busy) // [R8] [R9]
                    begin
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg[3:0] == `ACR_QUIET_CYCLES)
                        begin
                            st_reg <= ACR_CONV;
                            cnt_reg <= 6'h00;
                        end
                    end
                    else
                        cnt_reg <= 6'h00;
                ACR_CONV:
                    if (!delay_on || !lnk.bus_busy) // [R8]
                    begin
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == `ACR_CONV_CYCLES)
                        begin
                            st_reg <= ACR_IDLE;
                            // tag is the input just converted
                            result_reg <= {2'h0, chan_reg,
                                masked}; // [R12] [R14] [R19]
                        end
                    end
            endcase
        end
    end

    // byte stream out, high byte first
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lnk.rd_stb <= 1'b0;
            lnk.rd_byte <= 8'h00;
            lnk.rd_byte_hi <= 1'b0;
            hi_pend_reg <= 1'b0;
        end
        else
        begin
            lnk.rd_stb <= 1'b0;
            if (st_reg == ACR_CONV && cnt_reg == `ACR_CONV_CYCLES &&
                (!delay_on || !lnk.bus_busy))
            begin
                lnk.rd_stb <= 1'b1;
                lnk.rd_byte <= {2'h0, chan_reg, masked[11:8]}; // [R13]
                lnk.rd_byte_hi <= 1'b1;
                hi_pend_reg <= 1'b1;
            end
            else if (hi_pend_reg)
            begin
                lnk.rd_stb <= 1'b1;
                lnk.rd_byte <= result_reg[7:0]; // [R13]
                lnk.rd_byte_hi <= 1'b0;
                hi_pend_reg <= 1'b0;
            end
        end
    end

    // analog steering outputs
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mux_sel_o <= 2'h0;
            ext_ref_o <= 1'b0;
            filter_bypass_o <= 1'b0;
            setup_o <= `ACR_SETUP_RESET;
        end
        else
        begin
            mux_sel_o <= chan_reg;
            ext_ref_o <= setup_reg[`ACR_REFSEL_BIT]; // [R5] [R6]
            filter_bypass_o <= setup_reg[`ACR_BUS_GLITCH_FILTER_BYPASS_BIT]; // [R7]
            setup_o <= setup_reg;
        end
    end

endmodule : acr_device

// ==== src/acr_host.sv ====
/*
 controller end: AXI4-Lite slave registers driving the link.
 assumes a single AXI4-Lite master, one read and one write at a time.
*/
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "acr_cfg.svh"
module acr_host
    import acr_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // axi4-lite write
    input wire logic [31:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // axi4-lite read
    input wire logic [31:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // link
    acr_if.host lnk
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] aw_reg;
    logic aw_ok_reg;
    logic [31:0] w_reg;
    logic w_ok_reg;
    logic [15:0] result_reg;
    logic busy_reg;
    logic done_reg;
    logic [7:0] shadow_reg;
    logic do_wr;

    assign do_wr = aw_ok_reg && w_ok_reg && !bvalid_o;

    // write address/data capture in either order
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            awready_o <= 1'b1;
            wready_o <= 1'b1;
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            aw_reg <= 32'h00000000;
            w_reg <= 32'h00000000;
            bvalid_o <= 1'b0;
            bresp_o <= 2'h0;
        end
        else
        begin
            if (awvalid_i && awready_o)
            begin
                aw_reg <= awaddr_i;
                aw_ok_reg <= 1'b1;
                awready_o <= 1'b0;
            end
            if (wvalid_i && wready_o)
            begin
                w_reg <= wstrb_i[0] ? wdata_i : 32'h00000000;
                w_ok_reg <= 1'b1;
                wready_o <= 1'b0;
            end
            if (do_wr)
            begin
                bvalid_o <= 1'b1;
                bresp_o <= (aw_reg == `ACR_REG_SETUP ||
                    aw_reg == `ACR_REG_CTRL) ? 2'h0 : 2'h2;
                aw_ok_reg <= 1'b0;
                w_ok_reg <= 1'b0;
            end
            if (bvalid_o && bready_i)
            begin
                bvalid_o <= 1'b0;
                awready_o <= 1'b1;
                wready_o <= 1'b1;
            end
        end
    end

    // link drive: setup write and read request
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lnk.wr_stb <= 1'b0;
            lnk.wr_byte <= 8'h00;
            lnk.rd_req <= 1'b0;
            lnk.bus_busy <= 1'b0;
            shadow_reg <= `ACR_SETUP_RESET;
        end
        else
        begin
            lnk.wr_stb <= 1'b0;
            lnk.rd_req <= 1'b0;
            lnk.bus_busy <= 1'b0;
            if (do_wr && aw_reg == `ACR_REG_SETUP)
            begin
                lnk.wr_stb <= 1'b1; // [R17]
                lnk.wr_byte <= w_reg[7:0]; // [R3]
                lnk.bus_busy <= 1'b1;
                shadow_reg <= w_reg[7:0];
            end
            // start only with some enable set
            else if (do_wr && aw_reg == `ACR_REG_CTRL && w_reg[0] &&
                !busy_reg && (shadow_reg[`ACR_EN_MSB:`ACR_EN_LSB] &
                {~shadow_reg[`ACR_REFSEL_BIT], 3'h7}) != 4'h0)
                lnk.rd_req <= 1'b1; // [R4] [R11]
        end
    end

    // collect two result bytes
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            result_reg <= 16'h0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            if (lnk.rd_req)
                busy_reg <= 1'b1;
            if (lnk.rd_stb && lnk.rd_byte_hi)
                result_reg[15:8] <= lnk.rd_byte; // [R13]
            if (lnk.rd_stb && !lnk.rd_byte_hi)
            begin
                result_reg[7:0] <= lnk.rd_byte; // [R13]
                busy_reg <= 1'b0;
                done_reg <= 1'b1; // set wins
            end
            else if (arvalid_i && arready_o &&
                araddr_i == `ACR_REG_RESULT)
                done_reg <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h00000000;
            rresp_o <= 2'h0;
        end
        else if (arvalid_i && arready_o)
        begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b1;
            rresp_o <= 2'h0;
            unique case (araddr_i)
                `ACR_REG_CTRL: rdata_o <= 32'h00000000;
                `ACR_REG_SETUP: rdata_o <= {24'h000000, shadow_reg};
                `ACR_REG_STATUS: rdata_o <= {30'h0, done_reg, busy_reg};
                `ACR_REG_RESULT: rdata_o <= {16'h0000, result_reg};
                default:
                begin
                    rdata_o <= 32'h00000000;
                    rresp_o <= 2'h2;
                end
            endcase
        end
        else if (rvalid_o && rready_i)
        begin
            rvalid_o <= 1'b0;
            arready_o <= 1'b1;
        end
    end

endmodule : acr_host

// ==== verif/acr_link_sva.sv ====
/*
 checker on the link between controller end and converter end.
 assumes one clock, async active-low reset, signals taken from acr_if.
*/
`timescale 1ns/100ps
`include "acr_cfg.svh"
module acr_link_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // link
    input wire logic wr_stb,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input wire logic rd_stb,
    input wire logic [7:0] rd_byte,
    input wire logic rd_byte_hi,
    input wire logic bus_busy
);
    logic [7:0] setup_reg;
    ////////////////////////////////////////////////////////////
    // shadow of the setup byte as written over the link
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            setup_reg <= `ACR_SETUP_RESET;
        else if (wr_stb)
            setup_reg <= wr_byte;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_hi_lo; rd_stb && rd_byte_hi |=> rd_stb && !rd_byte_hi;
    endproperty
    a_hi_lo: assert property (p_hi_lo)
        else $error("low byte did not follow high byte");
    property p_lo_once; rd_stb && !rd_byte_hi |=> !rd_stb; endproperty
    a_lo_once: assert property (p_lo_once)
        else $error("extra byte after low byte");
    property p_lead_zero; rd_stb && rd_byte_hi |-> rd_byte[7:6] == 2'h0;
    endproperty
    a_lead_zero: assert property (p_lead_zero)
        else $error("leading bits of result not zero");
    property p_tag_on;
        rd_stb && rd_byte_hi |-> setup_reg[`ACR_EN_LSB + rd_byte[5:4]];
    endproperty
    a_tag_on: assert property (p_tag_on)
        else $error("result tagged with a disabled input");
    property p_ref_drop;
        rd_stb && rd_byte_hi && setup_reg[`ACR_REFSEL_BIT] |->
            rd_byte[5:4] != 2'h3;
    endproperty
    a_ref_drop: assert property (p_ref_drop)
        else $error("reference input converted");
    property p_no_early; rd_req |=> (!rd_stb) [*8]; endproperty
    a_no_early: assert property (p_no_early)
        else $error("result byte too soon after start");
    property p_answer; rd_req |-> ##[40:400] (rd_stb && rd_byte_hi);
    endproperty
    a_answer: assert property (p_answer)
        else $error("no result after start");
    property p_busy_wr; wr_stb |-> bus_busy; endproperty
    a_busy_wr: assert property (p_busy_wr)
        else $error("bus not busy during write");
    property p_wr_one; wr_stb |=> !wr_stb; endproperty
    a_wr_one: assert property (p_wr_one)
        else $error("more than one setup byte");
    c_ch3: cover property (rd_stb && rd_byte_hi && rd_byte[5:4] == 2'h3);
    c_ref: cover property (rd_stb && rd_byte_hi && setup_reg[3]);
    c_byp: cover property (wr_stb && wr_byte[2]);
endmodule : acr_link_sva

// ==== verif/adc_config_and_result_regs_tb_top.sv ====
/*
 bench: controller end and converter end joined by acr_if.
 assumes AXI4-Lite stimulus and a held code on sample_i per conversion.
*/
`timescale 1ns/100ps
`include "acr_cfg.svh"
module adc_config_and_result_regs_tb_top import acr_pkg::*;;
    logic mclk_i = '0;
    logic rst_b_i = '0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic awready, wready, bvalid, arready, rvalid, ext_ref, byp;
    logic [1:0] bresp, rresp;
    logic [11:0] sample = '0;
    logic [7:0] setup, hi_byte;
    logic [1:0] mux_sel;
    logic [3:0] wstrb = 4'hF;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'hD1D6;
    acr_if lnk ();
    ////////////////////////////////////////////////////////////
    initial forever #10 mclk_i = ~mclk_i;
    acr_host acr_host_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
        .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
        .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
        .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
        .rvalid_o(rvalid), .rready_i(rready), .lnk(lnk));
    acr_device #(.RES_BITS(12)) acr_device_i (.mclk_i(mclk_i),
        .rst_b_i(rst_b_i), .lnk(lnk), .sample_i(sample), .mux_sel_o(mux_sel),
        .ext_ref_o(ext_ref), .filter_bypass_o(byp), .setup_o(setup));
    acr_link_sva acr_link_sva_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .wr_stb(lnk.wr_stb), .wr_byte(lnk.wr_byte), .rd_req(lnk.rd_req),
        .rd_stb(lnk.rd_stb), .rd_byte(lnk.rd_byte),
        .rd_byte_hi(lnk.rd_byte_hi), .bus_busy(lnk.bus_busy));
    task automatic chk(input string what, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever
        begin
            @(posedge mclk_i);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid === 1'h1)
            begin
                r = bresp;
                bready <= 1'h0;
                break;
            end
        end
    endtask : axw
    task automatic axr(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever
        begin
            @(posedge mclk_i);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid === 1'h1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
    endtask : axr
    // one conversion: expected word noted, then polled and read back
    task automatic conv(input logic [1:0] tag);
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] e;
        d = $random(seed);
        e = {2'h0, tag, d[11:0]};
        sample <= d[11:0];
        exp_q.push_back(e);
        axw(`ACR_REG_CTRL, 32'h1, r);
        d = '0;
        while (d[1] !== 1'h1)
            axr(`ACR_REG_STATUS, d, r);
        axr(`ACR_REG_RESULT, d, r);
        chk("result reg", {16'h0, e}, d);
        chk("mux select", {30'h0, tag}, {30'h0, mux_sel});
    endtask : conv
    task automatic setcfg(input logic [7:0] v);
        logic [1:0] r;
        axw(`ACR_REG_SETUP, {24'h0, v}, r);
        repeat (4) @(posedge mclk_i);
        chk("setup", {24'h0, v}, {24'h0, setup});
        chk("ref bypass", {30'h0, v[3:2]}, {30'h0, ext_ref, byp});
    endtask : setcfg
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    // link monitor: rebuilds each two-byte result
    always @(posedge mclk_i)
    begin
        if (lnk.rd_stb === 1'h1 && lnk.rd_byte_hi === 1'h1)
            hi_byte = lnk.rd_byte;
        else if (lnk.rd_stb === 1'h1)
            chk("link word", {16'h0, exp_q.size() ? exp_q.pop_front() :
                16'hXXXX}, {16'h0, hi_byte, lnk.rd_byte});
    end
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (8) @(posedge mclk_i);
        rst_b_i <= 1'h1;
        @(posedge mclk_i);
        chk("reset setup", {24'h0, `ACR_SETUP_RESET}, {24'h0, setup});
        for (int i = 0; i < 4; i++)
            conv(2'(i));
        setcfg(8'h5F);
        conv(2'h0);
        conv(2'h2);
        setcfg(8'hF9);
        for (int i = 0; i < 4; i++)
            conv(2'(i % 3));
        // low strobe clears the setup byte, so a start must be refused
        wstrb <= 4'h0;
        axw(`ACR_REG_SETUP, 32'hFF, r);
        wstrb <= 4'hF;
        repeat (4) @(posedge mclk_i);
        chk("masked setup", 32'h0, {24'h0, setup});
        axw(`ACR_REG_CTRL, 32'h1, r);
        repeat (80) @(posedge mclk_i);
        axr(`ACR_REG_STATUS, d, r);
        chk("refused start", 32'h0, d);
        axr(32'h10, d, r);
        chk("unmapped read", 32'h2, {30'h0, r});
        axw(32'h20, 32'h5A, r);
        chk("unmapped write", 32'h2, {30'h0, r});
        chk("pending words", 32'h0, 32'(exp_q.size()));
        summarize();
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        summarize();
    end
endmodule : adc_config_and_result_regs_tb_top
